/* File: lrc_defs.svh */
// Offsets, field positions, reset values and timing for the regulator control block
// What this block does
// - Disabled regulator turns on output discharge
// - Short-circuit passes debounce before any action
// - Protected fault clears enable, sets flag
// - Per-regulator mask keeps flag off interrupt
// - Unprotected fault keeps regulator on, limiting
// - Protection enable resets cleared
// - Every debounced overload sets the fault flag
// - Five-bit code: 0.75V/50mV, then 1.8V/100mV
// - Enable clear: off; Run with enable: on
// - Standby needs enable and standby bit
// - Sleep needs enable and sleep bit
// - Fused switch mode drives pass fully on
// - No current limiting in switch mode
// - Soft-start on switch mode start-up
// - High-current regulator discharges during processor reset
// - High-current regulator: four-bit 1.8V/100mV code
// - High-current regulator uses same mode rules
`ifndef LRC_DEFS_SVH
`define LRC_DEFS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define LRC_CTRL0_OFS 8'h00
`define LRC_CTRL1_OFS 8'h04
`define LRC_CTRL2_OFS 8'h08
`define LRC_CFG_OFS 8'h0C
`define LRC_FAULT_OFS 8'h10
`define LRC_MASK_OFS 8'h14
`define LRC_STATUS_OFS 8'h18

// ----------------------------------------
// Control register fields
// ----------------------------------------
`define LRC_ON_BIT 0
`define LRC_STBY_BIT 1
`define LRC_SLEEP_BIT 2
`define LRC_LOWP_BIT 3
`define LRC_VCODE_LSB 8
`define LRC_VCODE_MSB 12
`define LRC_CFG_PROT_BIT 0
`define LRC_ST_ACT_LSB 0
`define LRC_ST_LOWP_LSB 4
`define LRC_ST_DEB_LSB 8
`define LRC_ST_SW_LSB 12

// ----------------------------------------
// Reset values
// ----------------------------------------
`define LRC_CTRL_RST 13'h0000
`define LRC_CFG_RST 1'h0
`define LRC_MASK_RST 3'h0

// ----------------------------------------
// Voltage decode, millivolts
// ----------------------------------------
`define LRC_LO_BASE_MV 12'h2EE
`define LRC_LO_STEP_MV 12'h032
`define LRC_HI_BASE_MV 12'h708
`define LRC_HI_STEP_MV 12'h064

// ----------------------------------------
// Timing defaults, in clock cycles
// ----------------------------------------
`define LRC_DEB_CYCLES 16
`define LRC_SS_CYCLES 100

`endif

/* File: lrc_pkg.sv */
// Types shared by the regulator control block
package lrc_pkg;

    typedef enum logic [1:0] {
        LRC_PS_RUN = 2'h0,
        LRC_PS_STANDBY = 2'h1,
        LRC_PS_SLEEP = 2'h2,
        LRC_PS_OFF = 2'h3
    } lrc_pstate_t;

    typedef enum logic [1:0] {
        LRC_RESP_OKAY = 2'h0,
        LRC_RESP_SLVERR = 2'h2
    } lrc_resp_t;

endpackage

/* File: lrc_top.sv */
// Control logic for three linear regulators with AXI4-Lite register access
`timescale 1ns/1ns
`include "lrc_defs.svh"

module lrc_top #(
    parameter int NUM_REG = 3,
    parameter int DEB_CYCLES = `LRC_DEB_CYCLES,
    parameter int SS_CYCLES = `LRC_SS_CYCLES,
    parameter int HC_IDX = 1
) (
    input wire logic clk_sys_in,
    input wire logic rstn_in,
    input wire logic [7:0] s_axi_awaddr_in,
    input wire logic s_axi_awvalid_in,
    output logic s_axi_awready_out,
    input wire logic [31:0] s_axi_wdata_in,
    input wire logic [3:0] s_axi_wstrb_in,
    input wire logic s_axi_wvalid_in,
    output logic s_axi_wready_out,
    output logic [1:0] s_axi_bresp_out,
    output logic s_axi_bvalid_out,
    input wire logic s_axi_bready_in,
    input wire logic [7:0] s_axi_araddr_in,
    input wire logic s_axi_arvalid_in,
    output logic s_axi_arready_out,
    output logic [31:0] s_axi_rdata_out,
    output logic [1:0] s_axi_rresp_out,
    output logic s_axi_rvalid_out,
    input wire logic s_axi_rready_in,
    input wire logic [1:0] power_state_in,
    input wire logic [2:0] short_circuit_in,
    input wire logic [2:0] fused_switch_mode_in,
    input wire logic processor_reset_out_n_in,
    output logic [2:0] reg_active_out,
    output logic [2:0] low_power_out,
    output logic [2:0] discharge_out,
    output logic [2:0] pass_full_on_out,
    output logic [2:0] current_limit_en_out,
    output logic [2:0] soft_start_out,
    output logic [11:0] target_mv0_out,
    output logic [11:0] target_mv1_out,
    output logic [11:0] target_mv2_out,
    output logic irq_out
);

    // ----------------------------------------
    // Reset synchroniser
    // ----------------------------------------
    logic [1:0] rst_sync_ff;
    logic rstn;

    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rst_sync_ff <= 2'h0;
        end else begin
            rst_sync_ff <= {rst_sync_ff[0], 1'h1};
        end
    end
    assign rstn = rst_sync_ff[1];

    // ----------------------------------------
    // State declarations
    // ----------------------------------------
    logic [12:0] ctrl_ff [NUM_REG];
    logic prot_en_ff;
    logic [2:0] fault_ff;
    logic [2:0] mask_ff;
    logic [2:0] active_ff;
    logic [2:0] lowp_ff;
    logic [2:0] dis_ff;
    logic [2:0] full_on_ff;
    logic [2:0] ilim_ff;
    logic [2:0] ss_ff;
    logic [2:0] deb_ff;
    logic [11:0] mv_ff [NUM_REG];
    logic irq_ff;
    logic [2:0] fault_evt;
    logic [2:0] nxt_active;
    logic [2:0] nxt_lowp;
    logic [2:0] sw_mode;

    // ----------------------------------------
    // AXI4-Lite write channel
    // ----------------------------------------
    logic awready_ff;
    logic wready_ff;
    logic aw_hold_ff;
    logic w_hold_ff;
    logic [7:0] aw_addr_ff;
    logic [31:0] w_data_ff;
    logic [3:0] w_strb_ff;
    logic bvalid_ff;
    logic [1:0] bresp_ff;
    logic wr_go;
    logic nxt_aw_hold;
    logic nxt_w_hold;
    logic nxt_bvalid;
    logic wr_mapped;

    assign wr_go = aw_hold_ff & w_hold_ff & ~bvalid_ff;
    assign nxt_aw_hold = wr_go ? 1'h0 : (aw_hold_ff | (s_axi_awvalid_in & awready_ff));
    assign nxt_w_hold = wr_go ? 1'h0 : (w_hold_ff | (s_axi_wvalid_in & wready_ff));
    assign nxt_bvalid = wr_go ? 1'h1 : (bvalid_ff & ~s_axi_bready_in);
    assign wr_mapped = (aw_addr_ff <= `LRC_STATUS_OFS) && (aw_addr_ff[1:0] == 2'h0);

    always_ff @(posedge clk_sys_in or negedge rstn) begin
        if (!rstn) begin
            aw_hold_ff <= 1'h0;
            w_hold_ff <= 1'h0;
            awready_ff <= 1'h0;
            wready_ff <= 1'h0;
            bvalid_ff <= 1'h0;
            bresp_ff <= 2'h0;
            aw_addr_ff <= 8'h00;
            w_data_ff <= 32'h0000_0000;
            w_strb_ff <= 4'h0;
        end else begin
            aw_hold_ff <= nxt_aw_hold;
            w_hold_ff <= nxt_w_hold;
            // One write in flight; ready drops once an item is held
            awready_ff <= ~nxt_aw_hold & ~nxt_bvalid;
            wready_ff <= ~nxt_w_hold & ~nxt_bvalid;
            bvalid_ff <= nxt_bvalid;
            if (s_axi_awvalid_in && awready_ff) begin
                aw_addr_ff <= s_axi_awaddr_in;
            end
            if (s_axi_wvalid_in && wready_ff) begin
                w_data_ff <= s_axi_wdata_in;
                w_strb_ff <= s_axi_wstrb_in;
            end
            if (wr_go) begin
                bresp_ff <= wr_mapped ? lrc_pkg::LRC_RESP_OKAY : lrc_pkg::LRC_RESP_SLVERR;
            end
        end
    end

    assign s_axi_awready_out = awready_ff;
    assign s_axi_wready_out = wready_ff;
    assign s_axi_bvalid_out = bvalid_ff;
    assign s_axi_bresp_out = bresp_ff;

    // Write strobes of the current write, per register
    logic [2:0] wr_ctrl;
    logic wr_cfg;
    logic wr_fault;
    logic wr_mask;

    always_comb begin
        wr_ctrl = 3'h0;
        wr_cfg = 1'h0;
        wr_fault = 1'h0;
        wr_mask = 1'h0;
        if (wr_go) begin
            unique case (aw_addr_ff)
                `LRC_CTRL0_OFS: wr_ctrl[0] = 1'h1;
                `LRC_CTRL1_OFS: wr_ctrl[1] = 1'h1;
                `LRC_CTRL2_OFS: wr_ctrl[2] = 1'h1;
                `LRC_CFG_OFS: wr_cfg = w_strb_ff[0];
                `LRC_FAULT_OFS: wr_fault = w_strb_ff[0];
                `LRC_MASK_OFS: wr_mask = w_strb_ff[0];
                default: wr_ctrl = 3'h0;
            endcase
        end
    end

    // ----------------------------------------
    // AXI4-Lite read channel
    // ----------------------------------------
    logic arready_ff;
    logic rvalid_ff;
    logic [31:0] rdata_ff;
    logic [1:0] rresp_ff;
    logic ar_take;
    logic nxt_rvalid;
    logic [31:0] rd_mux;
    logic rd_ok;

    assign ar_take = s_axi_arvalid_in & arready_ff;
    assign nxt_rvalid = ar_take ? 1'h1 : (rvalid_ff & ~s_axi_rready_in);

    always_comb begin
        rd_mux = 32'h0000_0000;
        rd_ok = 1'h1;
        unique case (s_axi_araddr_in)
            `LRC_CTRL0_OFS: rd_mux[12:0] = ctrl_ff[0];
            `LRC_CTRL1_OFS: rd_mux[12:0] = ctrl_ff[1];
            `LRC_CTRL2_OFS: rd_mux[12:0] = ctrl_ff[2];
            `LRC_CFG_OFS: rd_mux[`LRC_CFG_PROT_BIT] = prot_en_ff;
            `LRC_FAULT_OFS: rd_mux[2:0] = fault_ff;
            `LRC_MASK_OFS: rd_mux[2:0] = mask_ff;
            `LRC_STATUS_OFS: begin
                rd_mux[`LRC_ST_ACT_LSB +: 3] = active_ff;
                rd_mux[`LRC_ST_LOWP_LSB +: 3] = lowp_ff;
                rd_mux[`LRC_ST_DEB_LSB +: 3] = deb_ff;
                rd_mux[`LRC_ST_SW_LSB +: 3] = sw_mode;
            end
            default: rd_ok = 1'h0;
        endcase
    end

    always_ff @(posedge clk_sys_in or negedge rstn) begin
        if (!rstn) begin
            arready_ff <= 1'h0;
            rvalid_ff <= 1'h0;
            rdata_ff <= 32'h0000_0000;
            rresp_ff <= 2'h0;
        end else begin
            arready_ff <= ~nxt_rvalid;
            rvalid_ff <= nxt_rvalid;
            if (ar_take) begin
                rdata_ff <= rd_mux;
                rresp_ff <= rd_ok ? lrc_pkg::LRC_RESP_OKAY : lrc_pkg::LRC_RESP_SLVERR;
            end
        end
    end

    assign s_axi_arready_out = arready_ff;
    assign s_axi_rvalid_out = rvalid_ff;
    assign s_axi_rdata_out = rdata_ff;
    assign s_axi_rresp_out = rresp_ff;

    // ----------------------------------------
    // Global configuration, fault flags, mask
    // ----------------------------------------
    always_ff @(posedge clk_sys_in or negedge rstn) begin
        if (!rstn) begin
            prot_en_ff <= `LRC_CFG_RST;
            mask_ff <= `LRC_MASK_RST;
        end else begin
            if (wr_cfg) begin
                prot_en_ff <= w_data_ff[`LRC_CFG_PROT_BIT];
            end
            if (wr_mask) begin
                mask_ff <= w_data_ff[2:0];
            end
        end
    end

    always_ff @(posedge clk_sys_in or negedge rstn) begin
        if (!rstn) begin
            fault_ff <= 3'h0;
        end else begin
            // flag once per debounced overload on an active regulator; a new fault beats the clear
            fault_ff <= (fault_ff & ~(wr_fault ? w_data_ff[2:0] : 3'h0)) | fault_evt;
        end
    end

    always_ff @(posedge clk_sys_in or negedge rstn) begin
        if (!rstn) begin
            irq_ff <= 1'h0;
        end else begin
            // masked flags stay off the interrupt
            irq_ff <= |(fault_ff & ~mask_ff);
        end
    end
    assign irq_out = irq_ff;

    // ----------------------------------------
    // Voltage decode
    // ----------------------------------------
    function automatic logic [11:0] lrc_mv(input logic [4:0] code, input logic hc);
        logic [11:0] idx;
        idx = {8'h00, code[3:0]};
        // high-current regulator: 4-bit, upper range only
        if (hc || code[4]) begin
            lrc_mv = `LRC_HI_BASE_MV + `LRC_HI_STEP_MV * idx;
        end else begin
            lrc_mv = `LRC_LO_BASE_MV + `LRC_LO_STEP_MV * idx;
        end
    endfunction

    // ----------------------------------------
    // Per-regulator control
    // ----------------------------------------
    for (genvar i = 0; i < NUM_REG; i++) begin : g_reg
        localparam logic IS_HC = (i == HC_IDX);
        logic [15:0] deb_cnt_ff;
        logic [15:0] ss_cnt_ff;
        logic sc_raw;
        logic [12:0] wmask;

        // Only the low-current regulators have the fused switch option
        assign sw_mode[i] = IS_HC ? 1'h0 : fused_switch_mode_in[i];
        assign wmask = {{5{w_strb_ff[1]}}, 4'h0, {4{w_strb_ff[0]}}};

        always_comb begin
            nxt_active[i] = 1'h0;
            nxt_lowp[i] = 1'h0;
            if (ctrl_ff[i][`LRC_ON_BIT]) begin
                unique case (lrc_pkg::lrc_pstate_t'(power_state_in))
                    lrc_pkg::LRC_PS_RUN: nxt_active[i] = 1'h1;
                    lrc_pkg::LRC_PS_STANDBY: begin
                        nxt_active[i] = ctrl_ff[i][`LRC_STBY_BIT];
                        nxt_lowp[i] = ctrl_ff[i][`LRC_STBY_BIT] & ctrl_ff[i][`LRC_LOWP_BIT];
                    end
                    lrc_pkg::LRC_PS_SLEEP: begin
                        nxt_active[i] = ctrl_ff[i][`LRC_SLEEP_BIT];
                        nxt_lowp[i] = ctrl_ff[i][`LRC_SLEEP_BIT] & ctrl_ff[i][`LRC_LOWP_BIT];
                    end
                    lrc_pkg::LRC_PS_OFF: nxt_active[i] = 1'h0;
                endcase
            end
        end

        always_ff @(posedge clk_sys_in or negedge rstn) begin
            if (!rstn) begin
                ctrl_ff[i] <= `LRC_CTRL_RST;
            end else begin
                if (wr_ctrl[i]) begin
                    ctrl_ff[i] <= (ctrl_ff[i] & ~wmask) | (w_data_ff[12:0] & wmask);
                    if (IS_HC) begin
                        ctrl_ff[i][`LRC_VCODE_MSB] <= 1'h0;
                    end
                end
                // protected fault drops enable; otherwise it stays
                if (fault_evt[i] && prot_en_ff) begin
                    ctrl_ff[i][`LRC_ON_BIT] <= 1'h0;
                end
            end
        end

        // fault must persist before it counts
        assign sc_raw = short_circuit_in[i] & active_ff[i];
        assign fault_evt[i] = sc_raw & ~deb_ff[i] & (deb_cnt_ff == 16'(DEB_CYCLES - 1));

        always_ff @(posedge clk_sys_in or negedge rstn) begin
            if (!rstn) begin
                deb_cnt_ff <= 16'h0000;
                deb_ff[i] <= 1'h0;
            end else begin
                if (!sc_raw) begin
                    deb_cnt_ff <= 16'h0000;
                    deb_ff[i] <= 1'h0;
                end else if (deb_cnt_ff != 16'(DEB_CYCLES - 1)) begin
                    deb_cnt_ff <= deb_cnt_ff + 16'h0001;
                end else begin
                    deb_ff[i] <= 1'h1;
                end
            end
        end

        always_ff @(posedge clk_sys_in or negedge rstn) begin
            if (!rstn) begin
                active_ff[i] <= 1'h0;
                lowp_ff[i] <= 1'h0;
                dis_ff[i] <= 1'h1;
                full_on_ff[i] <= 1'h0;
                ilim_ff[i] <= 1'h0;
                mv_ff[i] <= 12'h000;
            end else begin
                active_ff[i] <= nxt_active[i];
                lowp_ff[i] <= nxt_lowp[i];
                // high-current regulator also while processor reset is low
                dis_ff[i] <= ~nxt_active[i] | (IS_HC & ~processor_reset_out_n_in);
                // fused switch drives pass fully on
                full_on_ff[i] <= nxt_active[i] & sw_mode[i];
                // no current limit in switch mode
                ilim_ff[i] <= nxt_active[i] & ~sw_mode[i];
                mv_ff[i] <= lrc_mv(ctrl_ff[i][`LRC_VCODE_MSB:`LRC_VCODE_LSB], IS_HC);
            end
        end

        // soft-start ramp on each start-up, switch mode included
        always_ff @(posedge clk_sys_in or negedge rstn) begin
            if (!rstn) begin
                ss_cnt_ff <= 16'h0000;
                ss_ff[i] <= 1'h0;
            end else begin
                if (nxt_active[i] && !active_ff[i]) begin
                    ss_cnt_ff <= 16'(SS_CYCLES);
                    ss_ff[i] <= 1'h1;
                end else if (!nxt_active[i] || ss_cnt_ff == 16'h0001) begin
                    ss_cnt_ff <= 16'h0000;
                    ss_ff[i] <= 1'h0;
                end else if (ss_cnt_ff != 16'h0000) begin
                    ss_cnt_ff <= ss_cnt_ff - 16'h0001;
                end
            end
        end
    end

    assign reg_active_out = active_ff;
    assign low_power_out = lowp_ff;
    assign discharge_out = dis_ff;
    assign pass_full_on_out = full_on_ff;
    assign current_limit_en_out = ilim_ff;
    assign soft_start_out = ss_ff;
    assign target_mv0_out = mv_ff[0];
    assign target_mv1_out = mv_ff[1];
    assign target_mv2_out = mv_ff[2];

endmodule

/* File: lrc_top_chk.sv */
// Port-level concurrent checks for the regulator control block
`timescale 1ns/1ns

module lrc_top_chk #(
    parameter int DEB_CYCLES = 16,
    parameter int SS_CYCLES = 100
) (
    input wire logic clk_sys_in,
    input wire logic rstn_in,
    input wire logic s_axi_awvalid_in,
    input wire logic s_axi_awready_out,
    input wire logic s_axi_wvalid_in,
    input wire logic s_axi_wready_out,
    input wire logic s_axi_bvalid_out,
    input wire logic [1:0] power_state_in,
    input wire logic [2:0] short_circuit_in,
    input wire logic processor_reset_out_n_in,
    input wire logic [2:0] reg_active_out,
    input wire logic [2:0] low_power_out,
    input wire logic [2:0] discharge_out,
    input wire logic [2:0] pass_full_on_out,
    input wire logic [2:0] current_limit_en_out,
    input wire logic [2:0] soft_start_out,
    input wire logic irq_out
);
    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (!rstn_in);

    AST_DISCH: assert property ((~reg_active_out & ~discharge_out) == 3'h0)
        else $error("Disabled regulator without discharge");
    AST_RST_DISCH: assert property (!processor_reset_out_n_in |=> discharge_out[1])
        else $error("No discharge during processor reset");
    AST_OFF: assert property (power_state_in == lrc_pkg::LRC_PS_OFF |=> reg_active_out == 3'h0)
        else $error("Regulator on in off state");
    AST_RUN_LP: assert property (power_state_in == lrc_pkg::LRC_PS_RUN |=> low_power_out == 3'h0)
        else $error("Low power in run state");
    // Regulator 1 holds its state for three cycles after its short rises
    AST_DEBOUNCE: assert property ($rose(short_circuit_in[1]) |=> $stable(reg_active_out[1]) [*3])
        else $error("Regulator changed before debounce");
    AST_SW_LIMIT: assert property ((pass_full_on_out & current_limit_en_out) == 3'h0)
        else $error("Current limit on in switch mode");
    AST_HC_SW: assert property (!pass_full_on_out[1])
        else $error("High-current regulator in switch mode");
    AST_SOFT: assert property ($rose(reg_active_out[0]) |-> soft_start_out[0] [*2])
        else $error("No soft start on start-up");
    AST_WR_LAT: assert property (s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in && s_axi_wready_out
        |=> !s_axi_bvalid_out ##1 s_axi_bvalid_out)
        else $error("Write response timing wrong");

    COV_IRQ: cover property ($rose(irq_out));
    COV_PROT: cover property ($fell(reg_active_out[1]) && short_circuit_in[1]);
    COV_SOFT: cover property ($rose(soft_start_out[0]));
endmodule

bind lrc_top lrc_top_chk #(.DEB_CYCLES(DEB_CYCLES), .SS_CYCLES(SS_CYCLES)) lrc_top_chk_inst (.*);

/* File: lrc_host.sv */
// Register bus master standing in for the host processor
`timescale 1ns/1ns

module lrc_host (
    input wire logic clk_sys_in,
    output logic [7:0] s_axi_awaddr_in,
    output logic s_axi_awvalid_in,
    input wire logic s_axi_awready_out,
    output logic [31:0] s_axi_wdata_in,
    output logic [3:0] s_axi_wstrb_in,
    output logic s_axi_wvalid_in,
    input wire logic s_axi_wready_out,
    input wire logic [1:0] s_axi_bresp_out,
    input wire logic s_axi_bvalid_out,
    output logic s_axi_bready_in,
    output logic [7:0] s_axi_araddr_in,
    output logic s_axi_arvalid_in,
    input wire logic s_axi_arready_out,
    input wire logic [31:0] s_axi_rdata_out,
    input wire logic [1:0] s_axi_rresp_out,
    input wire logic s_axi_rvalid_out,
    output logic s_axi_rready_in
);
    // Cycles of delay before accepting a write response
    int lazy = 0;

    initial begin
        {s_axi_awaddr_in, s_axi_awvalid_in, s_axi_wdata_in, s_axi_wvalid_in} = '0;
        {s_axi_bready_in, s_axi_araddr_in, s_axi_arvalid_in, s_axi_rready_in} = '0;
        s_axi_wstrb_in = 4'hF;
    end

    // ----------------------------------------
    // Bus cycles
    // ----------------------------------------
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic aw_ok;
        logic w_ok;
        @(posedge clk_sys_in);
        s_axi_awaddr_in <= a;
        s_axi_awvalid_in <= 1'b1;
        s_axi_wdata_in <= d;
        s_axi_wvalid_in <= 1'b1;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        while (!(aw_ok && w_ok)) begin
            @(posedge clk_sys_in);
            // Released lines flip so stale values never look valid
            if (!aw_ok && s_axi_awready_out) begin
                aw_ok = 1'b1;
                s_axi_awvalid_in <= 1'b0;
                s_axi_awaddr_in <= ~a;
            end
            if (!w_ok && s_axi_wready_out) begin
                w_ok = 1'b1;
                s_axi_wvalid_in <= 1'b0;
                s_axi_wdata_in <= ~d;
            end
        end
        repeat (lazy) @(posedge clk_sys_in);
        s_axi_bready_in <= 1'b1;
        do @(posedge clk_sys_in); while (!s_axi_bvalid_out);
        r = s_axi_bresp_out;
        s_axi_bready_in <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk_sys_in);
        s_axi_araddr_in <= a;
        s_axi_arvalid_in <= 1'b1;
        s_axi_rready_in <= 1'b1;
        do @(posedge clk_sys_in); while (!s_axi_arready_out);
        s_axi_arvalid_in <= 1'b0;
        s_axi_araddr_in <= ~a;
        do @(posedge clk_sys_in); while (!s_axi_rvalid_out);
        d = s_axi_rdata_out;
        r = s_axi_rresp_out;
        s_axi_rready_in <= 1'b0;
    endtask
endmodule

/* File: test_ldo_regulator_control.sv */
// Self-checking bench for the regulator control block
`timescale 1ns/1ns
`include "lrc_defs.svh"

module test_ldo_regulator_control;
    logic clk_sys_in, rstn_in, processor_reset_out_n_in, irq_out, on;
    logic [7:0] s_axi_awaddr_in, s_axi_araddr_in;
    logic [31:0] s_axi_wdata_in, s_axi_rdata_out;
    logic [3:0] s_axi_wstrb_in;
    logic s_axi_awvalid_in, s_axi_awready_out, s_axi_wvalid_in, s_axi_wready_out, s_axi_bvalid_out;
    logic s_axi_bready_in, s_axi_arvalid_in, s_axi_arready_out, s_axi_rvalid_out, s_axi_rready_in;
    logic [1:0] s_axi_bresp_out, s_axi_rresp_out, power_state_in;
    logic [2:0] short_circuit_in, fused_switch_mode_in, reg_active_out, low_power_out, discharge_out;
    logic [2:0] pass_full_on_out, current_limit_en_out, soft_start_out;
    logic [11:0] target_mv0_out, target_mv1_out, target_mv2_out;
    int num_errors = 0;
    int num_checks = 0;
    int codes[4] = '{0, 15, 16, 31};
    int mv;

    // Short debounce and soft start keep the run brief
    lrc_top #(.DEB_CYCLES(4), .SS_CYCLES(5)) lrc_top_inst (.*);
    lrc_host lrc_host_inst (.*);

    initial begin
        clk_sys_in = 1'b0;
        forever #5 clk_sys_in = ~clk_sys_in;
    end

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            num_errors++;
            $display("CHECK FAILED %s expected %0h seen %0h", n, e, g);
        end
    endtask

    task automatic wrr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = 2'h0);
        logic [1:0] r;
        lrc_host_inst.wr(a, d, r);
        chk("bresp", 32'(er), 32'(r));
        repeat (2) @(posedge clk_sys_in);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er = 2'h0);
        logic [31:0] d;
        logic [1:0] r;
        lrc_host_inst.rd(a, d, r);
        chk("rdata", e, d);
        chk("rresp", 32'(er), 32'(r));
    endtask

    task automatic hit(input logic [2:0] m, input int n);
        short_circuit_in <= m;
        repeat (n) @(posedge clk_sys_in);
        short_circuit_in <= 3'h0;
        repeat (3) @(posedge clk_sys_in);
    endtask

    task automatic summarize();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (30000) @(posedge clk_sys_in);
        num_errors++;
        summarize();
    end

    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        rstn_in = 1'b0;
        power_state_in = 2'h0;
        short_circuit_in = 3'h0;
        fused_switch_mode_in = 3'h0;
        processor_reset_out_n_in = 1'b1;
        repeat (12) @(posedge clk_sys_in);
        rstn_in <= 1'b1;
        repeat (4) @(posedge clk_sys_in);
        chk("active", 32'h0, 32'(reg_active_out));
        chk("disch", 32'h7, 32'(discharge_out));
        for (int a = 0; a < 28; a += 4) rdc(8'(a), 32'h0);
        rdc(8'h1C, 32'h0, 2'h2);
        wrr(8'h20, 32'h1, 2'h2);
        foreach (codes[i]) begin
            wrr(`LRC_CTRL0_OFS, 32'(codes[i]) << 8);
            wrr(`LRC_CTRL1_OFS, 32'(codes[i]) << 8);
            wrr(`LRC_CTRL2_OFS, 32'(codes[i]) << 8);
            mv = codes[i] < 16 ? 750 + 50 * codes[i] : 200 + 100 * codes[i];
            chk("mv0", 32'(mv), 32'(target_mv0_out));
            chk("mv2", 32'(mv), 32'(target_mv2_out));
            chk("mv1", 32'(1800 + 100 * (codes[i] % 16)), 32'(target_mv1_out));
        end
        rdc(`LRC_CTRL1_OFS, 32'h0F00);
        for (int r = 0; r < 3; r++) begin
            for (int p = 0; p < 4; p++) begin
                for (int b = 0; b < 16; b++) begin
                    power_state_in <= 2'(p);
                    wrr(8'(4 * r), 32'(b));
                    on = b[0] && (p == 0 || (p == 1 && b[1]) || (p == 2 && b[2]));
                    chk("active", 32'(on), 32'(reg_active_out[r]));
                    chk("lowpwr", 32'(on && p != 0 && b[3]), 32'(low_power_out[r]));
                    chk("disch", 32'(!on), 32'(discharge_out[r]));
                end
            end
            wrr(8'(4 * r), 32'h0);
        end
        power_state_in <= 2'h0;
        wrr(`LRC_CTRL0_OFS, 32'h1);
        hit(3'h1, 3);
        rdc(`LRC_FAULT_OFS, 32'h0);
        hit(3'h1, 12);
        chk("active", 32'h1, 32'(reg_active_out[0]));
        chk("limit", 32'h1, 32'(current_limit_en_out[0]));
        chk("irq", 32'h1, 32'(irq_out));
        rdc(`LRC_FAULT_OFS, 32'h1);
        wrr(`LRC_FAULT_OFS, 32'h1);
        chk("irq", 32'h0, 32'(irq_out));
        wrr(`LRC_MASK_OFS, 32'h1);
        lrc_host_inst.lazy = 3;
        hit(3'h1, 12);
        chk("irq", 32'h0, 32'(irq_out));
        wrr(`LRC_MASK_OFS, 32'h0);
        chk("irq", 32'h1, 32'(irq_out));
        wrr(`LRC_FAULT_OFS, 32'h1);
        lrc_host_inst.lazy = 0;
        wrr(`LRC_CFG_OFS, 32'h1);
        wrr(`LRC_CTRL1_OFS, 32'h1);
        hit(3'h2, 12);
        chk("active", 32'h0, 32'(reg_active_out[1]));
        chk("disch", 32'h1, 32'(discharge_out[1]));
        rdc(`LRC_CTRL1_OFS, 32'h0);
        rdc(`LRC_FAULT_OFS, 32'h2);
        wrr(`LRC_FAULT_OFS, 32'h2);
        wrr(`LRC_CFG_OFS, 32'h0);
        wrr(`LRC_CTRL1_OFS, 32'h1);
        chk("disch", 32'h0, 32'(discharge_out[1]));
        processor_reset_out_n_in <= 1'b0;
        repeat (2) @(posedge clk_sys_in);
        chk("disch", 32'h1, 32'(discharge_out[1]));
        processor_reset_out_n_in <= 1'b1;
        wrr(`LRC_CTRL0_OFS, 32'h0);
        fused_switch_mode_in <= 3'h3;
        wrr(`LRC_CTRL0_OFS, 32'h1);
        chk("swon", 32'h1, 32'(pass_full_on_out));
        chk("limit", 32'h0, 32'(current_limit_en_out[0]));
        chk("soft", 32'h1, 32'(soft_start_out[0]));
        repeat (8) @(posedge clk_sys_in);
        chk("soft", 32'h0, 32'(soft_start_out[0]));
        rdc(`LRC_STATUS_OFS, 32'h1003);
        summarize();
    end
endmodule
